// ===== hdl/trpb_pkg.sv
// Shared constants, field layouts and state codes of the thread request payload builder.
// Assumes a single 50 MHz core clock and a synchronous active-high reset.
package trpb_pkg;
	// ********************
	// Widths
	// ********************
	localparam int KSP_W = 26;
	localparam int BLK_W = 4;
	localparam int EXC_W = 8;
	localparam int SAMP_W = 3;
	localparam int BIND_W = 5;
	localparam int HND_W = 16;
	localparam int LEN_W = 6;
	localparam int IDX_W = 7;
	localparam int TRF_W = 256;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int TID_W = 16;
	localparam int UID_W = 4;
	// ********************
	// Register map
	// ********************
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] SCRB_OFF = 8'h04;
	localparam logic [7:0] SCRS_OFF = 8'h08;
	localparam logic [7:0] STAT_OFF = 8'h0c;
	localparam int CTRL_UID_LSB = 0;
	localparam int CTRL_DSR_LSB = 4;
	localparam int CTRL_EN_BIT = 11;
	localparam int CTRL_W = 12;
	localparam logic [11:0] CTRL_RST = 12'h810;
	localparam logic [31:0] SCRB_RST = 32'h0000_0000;
	localparam logic [31:0] SCRS_RST = 32'h0000_0400;
	localparam int STAT_MAP_LSB = 8;
	localparam int STAT_TID_LSB = 16;
	// ********************
	// Fixed header layout
	// ********************
	localparam int HDR_SCR_LSB = 0;
	localparam int HDR_TID_LSB = 32;
	localparam int HDR_UID_LSB = 48;
	localparam int HDR_DID_LSB = 64;
	localparam int HDR_HND_LSB = 96;
	// ********************
	// Sequencer states
	// ********************
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_OFFER = 6'h02,
		ST_EXT = 6'h04,
		ST_READ = 6'h08,
		ST_WAIT = 6'h10,
		ST_CAP = 6'h20
	} trpb_st_t;
endpackage

// ===== hdl/trpb_scr_mem.sv
// Small table holding the scratch offset of each active dispatch slot.
// Assumes one write and one read port on the core clock; read data are registered.
`timescale 1ns/1ps
`default_nettype none
module trpb_scr_mem #(
	parameter int AW_P = 3,
	parameter int DW_P = 32
) (
	input wire logic clk_sys_i,
	input wire logic we_i,
	input wire logic [AW_P-1:0] waddr_i,
	input wire logic [DW_P-1:0] wdata_i,
	input wire logic [AW_P-1:0] raddr_i,
	output logic [DW_P-1:0] rdata_o
);
	logic [DW_P-1:0] mem_r [0:(1<<AW_P)-1];

	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem_r[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_r[raddr_i];
	end
endmodule // trpb_scr_mem
`default_nettype wire

// ===== hdl/trpb_slot_alloc.sv
// Free pool of dispatch slots: hands out the lowest free slot, frees on termination.
// Assumes alloc is only raised while avail_o is high.
`timescale 1ns/1ps
`default_nettype none
module trpb_slot_alloc #(
	parameter int DID_W = 3
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic alloc_i,
	input wire logic free_i,
	input wire logic [DID_W-1:0] free_idx_i,
	output logic avail_o,
	output logic [DID_W-1:0] idx_o,
	output logic [(1<<DID_W)-1:0] busy_o
);
	typedef struct packed {
		logic [(1<<DID_W)-1:0] busy;
	} trpb_al_t;
	trpb_al_t r, n;

	always_comb begin
		n = r;
		avail_o = 1'b0;
		idx_o = '0;
		for (int i = (1<<DID_W)-1; i >= 0; i--) begin
			if (!r.busy[i]) begin
				avail_o = 1'b1;
				idx_o = DID_W'(i);
			end
		end
		// A grant and a release of one slot in the same cycle leave the slot taken.
		if (free_i) begin
			n.busy[free_idx_i] = 1'b0;
		end
		if (alloc_i && avail_o) begin
			n.busy[idx_o] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign busy_o = r.busy;
endmodule // trpb_slot_alloc
`default_nettype wire

// ===== hdl/trpb_top.sv
// Thread request payload builder: control word to the dispatcher, then payload into the
// thread register file (fixed header, extended header, shared entry buffer data).
// Assumes the stage, dispatcher, register file and shared buffer all run on clk_sys_i.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module trpb_top import trpb_pkg::*; #(
	parameter int DID_W = 3
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [AW-1:0] reg_addr_i,
	input wire logic [DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DW-1:0] reg_rdata_o,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [KSP_W-1:0] ksp_i,
	input wire logic [BLK_W-1:0] blk_cnt_i,
	input wire logic single_flow_flag_i,
	input wire logic prio_i,
	input wire logic fp_mode_i,
	input wire logic [EXC_W-1:0] exc_en_i,
	input wire logic [SAMP_W-1:0] samp_cnt_i,
	input wire logic [BIND_W-1:0] bind_cnt_i,
	input wire logic [HND_W-1:0] sb_handle_i,
	input wire logic [LEN_W-1:0] sb_len_i,
	input wire logic [TRF_W-1:0] ext_hdr_i,
	output logic disp_valid_o,
	input wire logic disp_ack_i,
	output logic [KSP_W-1:0] disp_ksp_o,
	output logic [BLK_W-1:0] disp_blk_o,
	output logic disp_sff_o,
	output logic disp_prio_o,
	output logic disp_fpm_o,
	output logic [EXC_W-1:0] disp_exc_o,
	output logic [SAMP_W-1:0] disp_samp_o,
	output logic [BIND_W-1:0] disp_bind_o,
	output logic [DID_W-1:0] disp_did_o,
	output logic trf_we_o,
	output logic [IDX_W-1:0] trf_idx_o,
	output logic [TRF_W-1:0] trf_data_o,
	output logic sb_rd_o,
	output logic [HND_W-1:0] sb_addr_o,
	input wire logic [TRF_W-1:0] sb_rdata_i,
	input wire logic term_i,
	input wire logic [DID_W-1:0] term_did_i,
	output logic freed_valid_o,
	output logic [DW-1:0] freed_scr_o
);
	if (DID_W < 1 || DID_W > 3) begin : g_bad_did
		$error("DID_W must lie in 1..3 so the slot map fits the status register.");
	end

	// ********************
	// State
	// ********************
	typedef struct packed {
		trpb_st_t st;
		logic [CTRL_W-1:0] ctrl;
		logic [DW-1:0] scrb;
		logic [DW-1:0] scrs;
		logic [DW-1:0] rdata;
		logic rdy;
		logic dv;
		logic [KSP_W-1:0] ksp;
		logic [BLK_W-1:0] blk;
		logic sff;
		logic prio;
		logic fpm;
		logic [EXC_W-1:0] exc;
		logic [SAMP_W-1:0] samp;
		logic [BIND_W-1:0] bnd;
		logic [DID_W-1:0] did;
		logic [HND_W-1:0] hnd;
		logic [LEN_W-1:0] len;
		logic [TRF_W-1:0] ext;
		logic [DW-1:0] scr;
		logic [UID_W-1:0] uid;
		logic [IDX_W-1:0] dsr;
		logic [TID_W-1:0] tid;
		logic [IDX_W-1:0] cnt;
		logic gwe;
		logic [IDX_W-1:0] gidx;
		logic [TRF_W-1:0] gdata;
		logic sbrd;
		logic [HND_W-1:0] sbaddr;
		logic fv;
		logic fvo;
		logic [DW-1:0] fscr;
	} trpb_top_t;
	trpb_top_t r, n;

	logic avail;
	logic [DID_W-1:0] free_idx;
	logic [(1<<DID_W)-1:0] busy_map;
	logic accept;
	logic [DW-1:0] scr_new;
	logic [DW-1:0] mem_rdata;

	function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
		return a == off;
	endfunction

	assign accept = (r.st == ST_IDLE) && r.rdy && req_valid_i;
	// Offset is relative to the general state base, so it is base plus slot times size.
	assign scr_new = DW'(r.scrb + DW'(r.scrs * DW'(free_idx)));

	// ********************
	// Slot pool and scratch table
	// ********************
	trpb_slot_alloc #(.DID_W(DID_W)) u_alloc (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.alloc_i(accept),
		.free_i(term_i),
		.free_idx_i(term_did_i),
		.avail_o(avail),
		.idx_o(free_idx),
		.busy_o(busy_map)
	);

	trpb_scr_mem #(.AW_P(DID_W), .DW_P(DW)) u_scr (
		.clk_sys_i(clk_sys_i),
		.we_i(accept),
		.waddr_i(free_idx),
		.wdata_i(scr_new),
		.raddr_i(term_did_i),
		.rdata_o(mem_rdata)
	);

	// ********************
	// Next state
	// ********************
	always_comb begin
		n = r;
		n.rdata = '0;
		n.gwe = 1'b0;
		n.sbrd = 1'b0;
		n.fv = term_i;
		n.fvo = r.fv;
		if (r.fv) begin
			n.fscr = mem_rdata;
		end
		if (reg_wr_i) begin
			if (hit(reg_addr_i, CTRL_OFF)) begin
				n.ctrl = reg_wdata_i[CTRL_W-1:0];
			end else if (hit(reg_addr_i, SCRB_OFF)) begin
				n.scrb = reg_wdata_i;
			end else if (hit(reg_addr_i, SCRS_OFF)) begin
				n.scrs = reg_wdata_i;
			end
		end
		if (reg_rd_i) begin
			if (hit(reg_addr_i, CTRL_OFF)) begin
				n.rdata = DW'(r.ctrl);
			end else if (hit(reg_addr_i, SCRB_OFF)) begin
				n.rdata = r.scrb;
			end else if (hit(reg_addr_i, SCRS_OFF)) begin
				n.rdata = r.scrs;
			end else if (hit(reg_addr_i, STAT_OFF)) begin
				n.rdata[0] = (r.st != ST_IDLE);
				n.rdata[STAT_MAP_LSB +: (1<<DID_W)] = busy_map;
				n.rdata[STAT_TID_LSB +: TID_W] = r.tid;
			end
		end
		case (r.st)
			ST_IDLE: begin
				n.rdy = r.ctrl[CTRL_EN_BIT] && avail;
				if (accept) begin
					n.rdy = 1'b0;
					n.dv = 1'b1;
					n.ksp = ksp_i;
					n.blk = blk_cnt_i;
					n.sff = single_flow_flag_i;
					n.prio = prio_i;
					n.fpm = fp_mode_i;
					n.exc = exc_en_i;
					// Hints go out untouched; the fetch path treats them like any fetch.
					n.samp = samp_cnt_i;
					n.bnd = bind_cnt_i;
					n.did = free_idx;
					n.hnd = sb_handle_i;
					n.len = sb_len_i;
					n.ext = ext_hdr_i;
					n.scr = scr_new;
					n.uid = r.ctrl[CTRL_UID_LSB +: UID_W];
					n.dsr = r.ctrl[CTRL_DSR_LSB +: IDX_W];
					n.tid = TID_W'(r.tid + TID_W'(1));
					n.st = ST_OFFER;
				end
			end
			ST_OFFER: begin
				// Control fields stay on their own ports; of them only the slot number (did) also enters the header.
				if (disp_ack_i) begin
					n.dv = 1'b0;
					n.gwe = 1'b1;
					n.gidx = '0;
					n.gdata = '0;
					n.gdata[HDR_SCR_LSB +: DW] = r.scr;
					n.gdata[HDR_TID_LSB +: TID_W] = r.tid;
					n.gdata[HDR_UID_LSB +: UID_W] = r.uid;
					n.gdata[HDR_DID_LSB +: DID_W] = r.did;
					n.gdata[HDR_HND_LSB +: HND_W] = r.hnd;
					n.cnt = IDX_W'(1);
					n.st = ST_EXT;
				end
			end
			ST_EXT: begin
				if (r.cnt < r.dsr) begin
					n.gwe = 1'b1;
					n.gidx = r.cnt;
					n.gdata = r.ext;
					n.cnt = IDX_W'(r.cnt + IDX_W'(1));
				end else begin
					n.cnt = '0;
					n.st = ST_READ;
				end
			end
			ST_READ: begin
				if (r.cnt < IDX_W'(r.len)) begin
					n.sbrd = 1'b1;
					n.sbaddr = HND_W'(r.hnd + HND_W'(r.cnt));
					n.st = ST_WAIT;
				end else begin
					n.st = ST_IDLE;
				end
			end
			ST_WAIT: begin
				// Read data arrive one cycle after the strobe.
				n.st = ST_CAP;
			end
			ST_CAP: begin
				n.gwe = 1'b1;
				n.gidx = IDX_W'(r.dsr + r.cnt);
				n.gdata = sb_rdata_i;
				n.cnt = IDX_W'(r.cnt + IDX_W'(1));
				n.st = ST_READ;
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.ctrl <= CTRL_RST;
			r.scrb <= SCRB_RST;
			r.scrs <= SCRS_RST;
		end else begin
			r <= n;
		end
	end

	// ********************
	// Outputs
	// ********************
	assign reg_rdata_o = r.rdata;
	assign req_ready_o = r.rdy;
	assign disp_valid_o = r.dv;
	assign disp_ksp_o = r.ksp;
	assign disp_blk_o = r.blk;
	assign disp_sff_o = r.sff;
	assign disp_prio_o = r.prio;
	assign disp_fpm_o = r.fpm;
	assign disp_exc_o = r.exc;
	assign disp_samp_o = r.samp;
	assign disp_bind_o = r.bnd;
	assign disp_did_o = r.did;
	assign trf_we_o = r.gwe;
	assign trf_idx_o = r.gidx;
	assign trf_data_o = r.gdata;
	assign sb_rd_o = r.sbrd;
	assign sb_addr_o = r.sbaddr;
	assign freed_valid_o = r.fvo;
	assign freed_scr_o = r.fscr;

	// ********************
	// Checks
	// ********************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	sequence s_offer_wait;
		disp_valid_o && !disp_ack_i;
	endsequence
	sequence s_buf_read;
		sb_rd_o ##2 trf_we_o;
	endsequence

	offer_hold_a: assert property (s_offer_wait |=> disp_valid_o && $stable(disp_ksp_o)
		&& $stable(disp_exc_o) && $stable(disp_did_o)) else $error("request changed before ack");
	ksp_pass_a: assert property (accept |=> disp_valid_o
		&& disp_ksp_o == $past(ksp_i)) else $error("kernel offset not passed");
	blk_pass_a: assert property (accept |=> disp_blk_o == $past(blk_cnt_i)
		&& disp_sff_o == $past(single_flow_flag_i)) else $error("block count or flag lost");
	hdr_first_a: assert property (disp_valid_o && disp_ack_i |=> trf_we_o
		&& trf_idx_o == '0 && !disp_valid_o) else $error("header not first in register zero");
	hdr_uid_a: assert property (trf_we_o && trf_idx_o == '0 |->
		trf_data_o[HDR_UID_LSB +: UID_W] == r.uid) else $error("unit identifier missing");
	buf_data_a: assert property (sb_rd_o |-> ##2 (trf_we_o
		&& trf_data_o == $past(sb_rdata_i))) else $error("buffer data not forwarded");
	data_start_a: assert property (s_buf_read |-> trf_idx_o >= r.dsr)
		else $error("buffer data below data start register");
	// No payload traffic while the control word waits, so an unaccepted request leaves no trace in the register file.
	no_early_a: assert property (disp_valid_o |-> !trf_we_o && !sb_rd_o)
		else $error("payload traffic before acceptance");
	tid_step_a: assert property (accept |=> r.tid == $past(r.tid) + TID_W'(1))
		else $error("thread identifier not advanced");
	scr_off_a: assert property ($rose(disp_valid_o) |-> r.scr
		== DW'(r.scrb + DW'(r.scrs * DW'(disp_did_o)))) else $error("scratch offset wrong");
	free_path_a: assert property (term_i |-> ##2 freed_valid_o)
		else $error("termination not reported");
endmodule // trpb_top
`default_nettype wire

// ===== testbench/trpb_partner.sv
// Stand-in for the thread dispatcher and the shared entry buffer.
// Assumes the builder's core clock; the dispatcher accepts after a programmable wait, once disp_blk_i is at most FREE_BLK.
`timescale 1ns/1ps
`default_nettype none
module trpb_partner import trpb_pkg::*; #(
	parameter int FREE_BLK = 8
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [3:0] ack_dly_i,
	input wire logic disp_valid_i,
	input wire logic [BLK_W-1:0] disp_blk_i,
	output logic disp_ack_o,
	input wire logic sb_rd_i,
	input wire logic [HND_W-1:0] sb_addr_i,
	output logic [TRF_W-1:0] sb_rdata_o
);
	logic [3:0] wait_r;

	// Only one request is ever pending here, so the high class is trivially served first.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !disp_valid_i || disp_ack_o) begin
			wait_r <= 4'h0;
			disp_ack_o <= 1'b0;
		end else if (wait_r >= ack_dly_i && disp_blk_i <= BLK_W'(FREE_BLK)) begin
			disp_ack_o <= 1'b1;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end

	// Outside a read the data keep turning over, so a capture one cycle late reads inverted data.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			sb_rdata_o <= '0;
		end else if (sb_rd_i) begin
			sb_rdata_o <= {8{sb_addr_i, ~sb_addr_i}};
		end else begin
			sb_rdata_o <= ~sb_rdata_o;
		end
	end
endmodule // trpb_partner
`default_nettype wire

// ===== testbench/trpb_top_tb.sv
// Self-checking bench for the thread request payload builder.
// Assumes the partner model answers for the dispatcher and the shared entry buffer.
`timescale 1ns/1ps
`default_nettype none
module trpb_top_tb import trpb_pkg::*;;
	logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, req_valid = 0, sff = 0, prio = 0;
	logic fpm = 0, term = 0, req_ready, disp_valid, disp_ack, trf_we, sb_rd, freed_valid;
	logic d_sff, d_prio, d_fpm;
	logic [AW-1:0] reg_addr = '0;
	logic [DW-1:0] reg_wdata = '0, reg_rdata, freed_scr;
	logic [KSP_W-1:0] ksp = '0, d_ksp;
	logic [BLK_W-1:0] blk = '0, d_blk;
	logic [EXC_W-1:0] exc = '0, d_exc;
	logic [SAMP_W-1:0] samp = '0, d_samp;
	logic [BIND_W-1:0] bnd = '0, d_bind;
	logic [HND_W-1:0] hnd = '0, sb_addr;
	logic [LEN_W-1:0] len = '0;
	logic [IDX_W-1:0] trf_idx;
	logic [TRF_W-1:0] ext = '0, trf_data, sb_rdata;
	logic [2:0] term_did = '0, did;
	logic [3:0] dly = '0;
	logic [TRF_W-1:0] trf_mem [128];
	logic [51:0] dbus_r;
	logic hold_r = 0;
	int fail_count = 0, num_checks = 0, cyc = 0, wr_cnt = 0;
	wire logic [51:0] dbus = {d_ksp, d_blk, d_sff, d_prio, d_fpm, d_exc, d_samp, d_bind, did};

	trpb_top trpb_top_i (.clk_sys_i(clk), .srst_i(srst), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.req_valid_i(req_valid), .req_ready_o(req_ready), .ksp_i(ksp), .blk_cnt_i(blk),
		.single_flow_flag_i(sff), .prio_i(prio), .fp_mode_i(fpm), .exc_en_i(exc),
		.samp_cnt_i(samp), .bind_cnt_i(bnd), .sb_handle_i(hnd), .sb_len_i(len), .ext_hdr_i(ext),
		.disp_valid_o(disp_valid), .disp_ack_i(disp_ack), .disp_ksp_o(d_ksp), .disp_blk_o(d_blk),
		.disp_sff_o(d_sff), .disp_prio_o(d_prio), .disp_fpm_o(d_fpm), .disp_exc_o(d_exc),
		.disp_samp_o(d_samp), .disp_bind_o(d_bind), .disp_did_o(did), .trf_we_o(trf_we),
		.trf_idx_o(trf_idx), .trf_data_o(trf_data), .sb_rd_o(sb_rd), .sb_addr_o(sb_addr),
		.sb_rdata_i(sb_rdata), .term_i(term), .term_did_i(term_did),
		.freed_valid_o(freed_valid), .freed_scr_o(freed_scr));

	trpb_partner trpb_partner_i (.clk_sys_i(clk), .srst_i(srst), .ack_dly_i(dly),
		.disp_valid_i(disp_valid), .disp_blk_i(d_blk), .disp_ack_o(disp_ack), .sb_rd_i(sb_rd),
		.sb_addr_i(sb_addr), .sb_rdata_o(sb_rdata));

	initial forever #10 clk = ~clk;

	// ********************
	// Checking helpers
	// ********************
	task close_out;
		if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic [TRF_W-1:0] got, input logic [TRF_W-1:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask

	// The ceiling is far above the few hundred cycles that the sequence needs.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end

	// The monitor keeps every register file write and watches a pending request stand still.
	always @(posedge clk) begin
		if (trf_we) begin
			trf_mem[trf_idx] = trf_data;
			wr_cnt++;
		end
		if (hold_r) chk(dbus, dbus_r, "fields moved before accept");
		hold_r = disp_valid && !disp_ack;
		dbus_r = dbus;
	end

	// ********************
	// Bus tasks
	// ********************
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, e, "register read");
	endtask

	task stop(input logic [2:0] d, input logic [31:0] s);
		@(posedge clk);
		term <= 1'b1;
		term_did <= d;
		@(posedge clk);
		term <= 1'b0;
		@(negedge clk);
		chk(freed_valid, 1'b0, "free too early");
		@(negedge clk);
		chk(freed_valid, 1'b1, "free pulse missing");
		chk(freed_scr, s, "freed scratch offset");
	endtask

	// One whole request: offer, accept after w cycles, then check the loaded registers.
	task run(input logic [15:0] h, input logic [5:0] n, input logic [3:0] w, input logic p,
		input logic [2:0] d, input logic [15:0] tid, input logic [31:0] s);
		int k;
		logic [15:0] a;
		logic [TRF_W-1:0] hd;
		wr_cnt = 0;
		@(posedge clk);
		hnd <= h;
		len <= n;
		dly <= w;
		prio <= p;
		ksp <= {10'h000, h};
		blk <= {1'b0, h[2:0]};
		sff <= h[0];
		fpm <= h[1];
		exc <= h[7:0];
		samp <= h[2:0];
		bnd <= h[4:0];
		ext <= {16{h}};
		req_valid <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (req_ready !== 1'b1 && k < 50);
		req_valid <= 1'b0;
		@(negedge clk);
		chk(disp_valid, 1'b1, "no dispatch request");
		chk(dbus, {ksp, blk, sff, p, fpm, exc, samp, bnd, d}, "control fields");
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (req_ready !== 1'b1 && k < 400);
		chk(req_ready, 1'b1, "payload never finished");
		hd = '0;
		hd[31:0] = s;
		hd[47:32] = tid;
		hd[51:48] = 4'h5;
		hd[64+:3] = d;
		hd[111:96] = h;
		chk(wr_cnt, 3 + n, "register write count");
		chk(trf_mem[0], hd, "header register");
		for (k = 1; k < 3; k++) chk(trf_mem[k], {16{h}}, "extended header");
		for (k = 0; k < n; k++) begin
			a = h + 16'(k);
			chk(trf_mem[3 + k], {8{a, ~a}}, "payload data");
		end
	endtask

	// ********************
	// Main sequence
	// ********************
	initial begin
		repeat (12) @(posedge clk);
		chk(req_ready, 1'b0, "ready during reset");
		srst <= 1'b0;
		rd(CTRL_OFF, {20'h00000, CTRL_RST});
		rd(SCRB_OFF, SCRB_RST);
		rd(SCRS_OFF, SCRS_RST);
		rd(STAT_OFF, 32'h0000_0000);
		wr(CTRL_OFF, 32'hffff_f835);
		wr(SCRB_OFF, 32'h0000_1000);
		wr(SCRS_OFF, 32'h0000_0200);
		wr(8'h10, 32'hffff_ffff);
		rd(CTRL_OFF, 32'h0000_0835);
		rd(8'h10, 32'h0000_0000);
		run(16'h00a3, 6'h04, 4'h0, 1'b0, 3'h0, 16'h0001, 32'h0000_1000);
		run(16'h1f5e, 6'h00, 4'h6, 1'b1, 3'h1, 16'h0002, 32'h0000_1200);
		stop(3'h0, 32'h0000_1000);
		run(16'hfffe, 6'h3f, 4'h2, 1'b0, 3'h0, 16'h0003, 32'h0000_1000);
		rd(STAT_OFF, 32'h0003_0300);
		wr(CTRL_OFF, 32'h0000_0035);
		rd(CTRL_OFF, 32'h0000_0035);
		chk(req_ready, 1'b0, "ready while disabled");
		close_out();
	end
endmodule // trpb_top_tb
`default_nettype wire
